// [srrc_core_model.sv]
// Purpose: reset vector table behind the core
// Assumes: data answers in the same cycle
// Notes: vector reads back as 1234h
`timescale 1ns/1ps
module srrc_core_model (
	input wire logic i_clk,
	input wire logic [15:0] i_vector_addr,
	output logic [15:0] o_data
);
	logic t_q = 0;
	// toggles so unread data never looks stable
	always @(posedge i_clk) t_q <= ~t_q;
	// low bytes of the two vector words
	assign o_data = i_vector_addr == 16'h0000 ? 16'ha534 :
		i_vector_addr == 16'h0001 ? 16'h5a12 : {16{t_q}};
endmodule // srrc_core_model

// [srrc_ctrl.v]
// Purpose: stop release and reset sequencing with reset value image
// Assumes: inputs synchronous to i_clk except i_resetn
// Notes: settle counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`include "srrc_defines.vh"
module srrc_ctrl #(
	parameter [31:0] SETTLE_2P12 = `SRRC_SETTLE_2P12,
	parameter [31:0] SETTLE_2P15 = `SRRC_SETTLE_2P15,
	parameter [31:0] SETTLE_2P17 = `SRRC_SETTLE_2P17
) (
	input wire i_clk,
	input wire i_resetn,
	input wire i_wdt_overflow,
	input wire i_stop_instr,
	input wire i_irq_pending,
	input wire i_interrupt_mask_flag,
	input wire i_global_interrupt_enable,
	input wire i_standby,
	input wire [2:0] i_osc_settle_select,
	input wire i_osc_settle_select_we,
	input wire [15:0] i_vector_data,
	output reg o_core_resetn,
	output reg o_cpu_run,
	output reg o_osc_stop,
	output reg o_pins_hiz,
	output reg o_vector_rd,
	output reg [15:0] o_vector_addr,
	output reg o_pc_load,
	output reg [15:0] o_pc,
	output reg o_wake_service,
	output reg o_wake_resume,
	output reg o_ram_retain,
	output reg [2:0] o_osc_settle_select,
	output reg [7:0] o_processor_flags_word,
	output reg [7:0] o_cpu_clock_control,
	output reg [7:0] o_port_latch,
	output reg [7:0] o_port_direction_reg,
	output reg [7:0] o_pullup_option_reg,
	output reg [7:0] o_pullup_option_reg_b,
	output reg [7:0] o_interrupt_request_flags,
	output reg [7:0] o_interrupt_mask_reg,
	output reg [7:0] o_external_edge_mode,
	output reg [15:0] o_wide_timer_count,
	output reg [15:0] o_wide_timer_compare,
	output reg [7:0] o_wide_timer_mode,
	output reg [7:0] o_buzzer_control,
	output reg [7:0] o_narrow_timer_count,
	output reg [7:0] o_narrow_timer_mode,
	output reg [7:0] o_watchdog_clock_select,
	output reg [7:0] o_watchdog_mode_reg,
	output reg [7:0] o_sync_serial_mode,
	output reg [7:0] o_async_serial_mode,
	output reg [7:0] o_async_serial_status,
	output reg [7:0] o_baud_generator_control,
	output reg [7:0] o_transmit_shifter
);
	localparam [5:0] ST_SETTLE = 6'b000001;
	localparam [5:0] ST_VEC_LO = 6'b000010;
	localparam [5:0] ST_VEC_HI = 6'b000100;
	localparam [5:0] ST_RUN = 6'b001000;
	localparam [5:0] ST_STOP = 6'b010000;
	localparam [5:0] ST_WAKE = 6'b100000;

	reg [5:0] state_q;
	reg [31:0] cnt_q;
	reg after_reset_q;
	reg [7:0] vec_lo_q;
	reg wdt_rst_q;
	reg in_standby_q;
	wire sync_resetn;
	// reset code is a byte, the register keeps bits 2:0
	localparam [7:0] SETTLE_SEL_RST = `SRRC_SETTLE_SEL_RST;

	// settle count for a select code
	function [31:0] settle_cycles;
		input [2:0] sel;
		begin
			case (sel)
				`SRRC_SEL_2P12: settle_cycles = SETTLE_2P12;
				`SRRC_SEL_2P15: settle_cycles = SETTLE_2P15;
				default: settle_cycles = SETTLE_2P17;
			endcase
		end
	endfunction

	// watchdog overflow pulses a reset that clears itself
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			wdt_rst_q <= 1'b0;
		else
			wdt_rst_q <= i_wdt_overflow;
	end

	// both sources merge into one reset
	srrc_reset_sync u_sync (
		.i_clk(i_clk),
		.i_resetn_src(i_resetn & ~wdt_rst_q),
		.o_resetn(sync_resetn)
	);

	// standby memory for ram retention across reset
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			in_standby_q <= 1'b0;
		else
			in_standby_q <= i_standby | (state_q == ST_STOP);
	end

	// sequencer: settle, vector fetch, run, stop, wake
	always @(posedge i_clk or negedge sync_resetn) begin
		if (!sync_resetn) begin
			state_q <= ST_SETTLE;
			cnt_q <= 32'd0;
			after_reset_q <= 1'b1;
			vec_lo_q <= 8'h00;
			o_core_resetn <= 1'b0;
			o_cpu_run <= 1'b0;
			o_osc_stop <= 1'b0;
			o_pins_hiz <= 1'b1;
			o_vector_rd <= 1'b0;
			o_vector_addr <= `SRRC_VECTOR_LO;
			o_pc_load <= 1'b0;
			o_pc <= 16'h0000; // don't care until load
			o_wake_service <= 1'b0;
			o_wake_resume <= 1'b0;
		end else begin
			o_pc_load <= 1'b0;
			o_wake_service <= 1'b0;
			o_wake_resume <= 1'b0;
			o_vector_rd <= 1'b0;
			case (state_q)
				ST_SETTLE: begin
					o_pins_hiz <= 1'b1;
					o_core_resetn <= 1'b1;
					// post-reset wait is fixed at 2^15
					if (cnt_q >= SETTLE_2P15 - 32'd1) begin
						cnt_q <= 32'd0;
						state_q <= ST_VEC_LO;
						o_vector_rd <= 1'b1;
						o_vector_addr <= `SRRC_VECTOR_LO;
					end else begin
						cnt_q <= cnt_q + 32'd1;
					end
				end
				ST_VEC_LO: begin
					vec_lo_q <= i_vector_data[7:0];
					o_vector_rd <= 1'b1;
					o_vector_addr <= `SRRC_VECTOR_HI;
					state_q <= ST_VEC_HI;
				end
				ST_VEC_HI: begin
					o_pc <= {i_vector_data[7:0], vec_lo_q};
					o_pc_load <= 1'b1;
					o_pins_hiz <= 1'b0;
					o_cpu_run <= 1'b1;
					after_reset_q <= 1'b0;
					state_q <= ST_RUN;
				end
				ST_RUN: begin
					if (i_stop_instr) begin
						o_osc_stop <= 1'b1;
						o_cpu_run <= 1'b0;
						state_q <= ST_STOP;
					end
				end
				ST_STOP: begin
					// masked requests keep the device stopped
					if (i_irq_pending && !i_interrupt_mask_flag) begin
						o_osc_stop <= 1'b0;
						cnt_q <= settle_cycles(o_osc_settle_select);
						state_q <= ST_WAKE;
					end
				end
				ST_WAKE: begin
					if (cnt_q <= 32'd1) begin
						cnt_q <= 32'd0;
						o_cpu_run <= 1'b1;
						o_wake_service <= i_global_interrupt_enable;
						o_wake_resume <= ~i_global_interrupt_enable;
						state_q <= ST_RUN;
					end else begin
						cnt_q <= cnt_q - 32'd1;
					end
				end
				default: state_q <= ST_SETTLE;
			endcase
		end
	end

	// ram retention flag set from standby while sync_resetn is low
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			o_ram_retain <= 1'b0;
		else if (!sync_resetn)
			o_ram_retain <= in_standby_q | o_ram_retain;
		else if (state_q == ST_RUN)
			o_ram_retain <= 1'b0;
	end

	// settle select register, writable while running
	always @(posedge i_clk or negedge sync_resetn) begin
		if (!sync_resetn)
			o_osc_settle_select <= SETTLE_SEL_RST[2:0];
		else if (i_osc_settle_select_we)
			o_osc_settle_select <= i_osc_settle_select;
	end

	// core flags and clock control image, held between resets
	always @(posedge i_clk or negedge sync_resetn) begin
		if (!sync_resetn) begin
			o_processor_flags_word <= `SRRC_FLAGS_RST;
			o_cpu_clock_control <= `SRRC_CLK_CTRL_RST;
		end else begin
			o_processor_flags_word <= o_processor_flags_word;
			o_cpu_clock_control <= o_cpu_clock_control;
		end
	end

	// port latch, direction and pull-up image
	always @(posedge i_clk or negedge sync_resetn) begin
		if (!sync_resetn) begin
			o_port_latch <= `SRRC_PORT_LATCH_RST;
			o_port_direction_reg <= `SRRC_PORT_DIR_RST;
			o_pullup_option_reg <= `SRRC_PULLUP_RST;
			o_pullup_option_reg_b <= `SRRC_PULLUP_RST;
		end else begin
			o_port_latch <= o_port_latch;
			o_port_direction_reg <= o_port_direction_reg;
			o_pullup_option_reg <= o_pullup_option_reg;
			o_pullup_option_reg_b <= o_pullup_option_reg_b;
		end
	end

	// interrupt flags, masks and edge mode image
	always @(posedge i_clk or negedge sync_resetn) begin
		if (!sync_resetn) begin
			o_interrupt_request_flags <= `SRRC_IRQ_FLAG_RST;
			o_interrupt_mask_reg <= `SRRC_IRQ_MASK_RST;
			o_external_edge_mode <= `SRRC_EDGE_MODE_RST;
		end else begin
			o_interrupt_request_flags <= o_interrupt_request_flags;
			o_interrupt_mask_reg <= o_interrupt_mask_reg;
			o_external_edge_mode <= o_external_edge_mode;
		end
	end

	// wide timer and buzzer image
	always @(posedge i_clk or negedge sync_resetn) begin
		if (!sync_resetn) begin
			o_wide_timer_count <= `SRRC_WIDE_CNT_RST;
			o_wide_timer_compare <= `SRRC_WIDE_CMP_RST;
			o_wide_timer_mode <= `SRRC_WIDE_MODE_RST;
			o_buzzer_control <= `SRRC_BUZZER_RST;
		end else begin
			o_wide_timer_count <= o_wide_timer_count;
			o_wide_timer_compare <= o_wide_timer_compare;
			o_wide_timer_mode <= o_wide_timer_mode;
			o_buzzer_control <= o_buzzer_control;
		end
	end

	// narrow timer image
	always @(posedge i_clk or negedge sync_resetn) begin
		if (!sync_resetn) begin
			o_narrow_timer_count <= `SRRC_NARROW_CNT_RST;
			o_narrow_timer_mode <= `SRRC_NARROW_MODE_RST;
		end else begin
			o_narrow_timer_count <= o_narrow_timer_count;
			o_narrow_timer_mode <= o_narrow_timer_mode;
		end
	end

	// watchdog select and mode image
	always @(posedge i_clk or negedge sync_resetn) begin
		if (!sync_resetn) begin
			o_watchdog_clock_select <= `SRRC_WDT_SEL_RST;
			o_watchdog_mode_reg <= `SRRC_WDT_MODE_RST;
		end else begin
			o_watchdog_clock_select <= o_watchdog_clock_select;
			o_watchdog_mode_reg <= o_watchdog_mode_reg;
		end
	end

	// clocked serial mode image
	always @(posedge i_clk or negedge sync_resetn) begin
		if (!sync_resetn) begin
			o_sync_serial_mode <= `SRRC_SER_RST;
		end else begin
			o_sync_serial_mode <= o_sync_serial_mode;
		end
	end

	// asynchronous serial and shifter image; shifter idles all ones
	always @(posedge i_clk or negedge sync_resetn) begin
		if (!sync_resetn) begin
			o_async_serial_mode <= `SRRC_SER_RST;
			o_async_serial_status <= `SRRC_SER_RST;
			o_baud_generator_control <= `SRRC_SER_RST;
			o_transmit_shifter <= `SRRC_TX_SHIFT_RST;
		end else begin
			o_async_serial_mode <= o_async_serial_mode;
			o_async_serial_status <= o_async_serial_status;
			o_baud_generator_control <= o_baud_generator_control;
			o_transmit_shifter <= o_transmit_shifter;
		end
	end
endmodule // srrc_ctrl

// [srrc_ctrl_checker.sv]
// Purpose: port checker for srrc_ctrl
// Assumes: one clock, reset active low
// Notes: attached by bind
`timescale 1ns/1ps
module srrc_ctrl_checker (
	input wire i_clk,
	input wire i_resetn,
	input wire i_wdt_overflow,
	input wire i_interrupt_mask_flag,
	input wire i_global_interrupt_enable,
	input wire [15:0] i_vector_data,
	input wire o_core_resetn,
	input wire o_cpu_run,
	input wire o_osc_stop,
	input wire o_pins_hiz,
	input wire o_vector_rd,
	input wire [15:0] o_vector_addr,
	input wire o_pc_load,
	input wire [15:0] o_pc,
	input wire o_wake_service,
	input wire o_wake_resume
);
	wire [7:0] vlo = i_vector_data[7:0];
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// reset, vector fetch and wake relations
	property p_hiz; !o_core_resetn |-> o_pins_hiz; endproperty
	a_hiz: assert property (p_hiz) else $error("pins driven");
	property p_vec; o_vector_rd && o_vector_addr == 16'h0000 |=> ##1 o_pc_load;
	endproperty
	a_vec: assert property (p_vec) else $error("no pc load");
	property p_pc; o_pc_load |-> o_pc == {$past(vlo), $past(vlo, 2)}; endproperty
	a_pc: assert property (p_pc) else $error("bad pc");
	property p_run; o_pc_load |-> o_cpu_run && !o_pins_hiz; endproperty
	a_run: assert property (p_run) else $error("not running");
	property p_wdt; i_wdt_overflow |-> ##[1:3] !o_core_resetn; endproperty
	a_wdt: assert property (p_wdt) else $error("no wdt reset");
	property p_mask; o_osc_stop && i_interrupt_mask_flag |=> o_osc_stop;
	endproperty
	a_mask: assert property (p_mask) else $error("masked wake");
	property p_srv; o_wake_service |-> $past(i_global_interrupt_enable);
	endproperty
	a_srv: assert property (p_srv) else $error("bad service");
	property p_res; o_wake_resume |-> !$past(i_global_interrupt_enable);
	endproperty
	a_res: assert property (p_res) else $error("bad resume");
	c_srv: cover property (o_wake_service);
	c_res: cover property (o_wake_resume);
	c_wdt: cover property (i_wdt_overflow ##1 !o_core_resetn);
endmodule // srrc_ctrl_checker
bind srrc_ctrl srrc_ctrl_checker u_chk (
	.i_clk(i_clk),
	.i_resetn(i_resetn),
	.i_wdt_overflow(i_wdt_overflow),
	.i_interrupt_mask_flag(i_interrupt_mask_flag),
	.i_global_interrupt_enable(i_global_interrupt_enable),
	.i_vector_data(i_vector_data),
	.o_core_resetn(o_core_resetn),
	.o_cpu_run(o_cpu_run),
	.o_osc_stop(o_osc_stop),
	.o_pins_hiz(o_pins_hiz),
	.o_vector_rd(o_vector_rd),
	.o_vector_addr(o_vector_addr),
	.o_pc_load(o_pc_load),
	.o_pc(o_pc),
	.o_wake_service(o_wake_service),
	.o_wake_resume(o_wake_resume)
);

// [srrc_defines.vh]
// Purpose: constants for the stop release and reset control block
// Assumes: system clock is the only clock, 100 MHz
// Notes: reset values are the image loaded into core and peripherals
// Function
// - unmasked pending interrupt wakes stop after settle
// - mask/enable choose resume, service, or stay
// - reset in stop acts after settle time
// - pin low or watchdog overflow resets alike
// - execution starts at vector 0000H/0001H
// - pins high impedance during reset and settle
// - pin high releases reset after settle (o_core_resetn here rises at settle start)
// - watchdog reset clears itself, then settle
// - stop contents kept under reset, ports float
// - pc undefined until vector load
// - flags word resets to 02H
// - port latches 00H, direction FFH, pullups 00H
// - request flags 00H, masks FFH, edge 00H
// - clock control 02H, settle select 04H
// - wide timer 0000H, compare FFFFH, modes 0
// - narrow timer and mode reset to 00H
// - watchdog select and mode reset 00H
// - serial regs 00H, transmit shifter FFH
// - ram kept across reset from standby
// - post-reset settle is 2^15 clocks
// - stop instruction halts oscillator and cpu
`ifndef SRRC_DEFINES_VH
`define SRRC_DEFINES_VH

`define SRRC_VECTOR_LO 16'h0000
`define SRRC_VECTOR_HI 16'h0001
`define SRRC_FLAGS_RST 8'h02
`define SRRC_PORT_LATCH_RST 8'h00
`define SRRC_PORT_DIR_RST 8'hff
`define SRRC_PULLUP_RST 8'h00
`define SRRC_IRQ_FLAG_RST 8'h00
`define SRRC_IRQ_MASK_RST 8'hff
`define SRRC_EDGE_MODE_RST 8'h00
`define SRRC_CLK_CTRL_RST 8'h02
`define SRRC_SETTLE_SEL_RST 8'h04
`define SRRC_WIDE_CNT_RST 16'h0000
`define SRRC_WIDE_CMP_RST 16'hffff
`define SRRC_WIDE_MODE_RST 8'h00
`define SRRC_BUZZER_RST 8'h00
`define SRRC_NARROW_CNT_RST 8'h00
`define SRRC_NARROW_MODE_RST 8'h00
`define SRRC_WDT_SEL_RST 8'h00
`define SRRC_WDT_MODE_RST 8'h00
`define SRRC_SER_RST 8'h00
`define SRRC_TX_SHIFT_RST 8'hff
// settle select codes
`define SRRC_SEL_2P12 3'h0
`define SRRC_SEL_2P15 3'h2
`define SRRC_SEL_2P17 3'h4
// settle times in clock periods
`define SRRC_SETTLE_2P12 32'd4096
`define SRRC_SETTLE_2P15 32'd32768
`define SRRC_SETTLE_2P17 32'd131072
// external pin least low time, ns
`define SRRC_PIN_LOW_NS 10000
`define SRRC_CLK_NS 10

`endif

// [srrc_reset_sync.v]
// Purpose: reset synchroniser, async assert, sync release
// Assumes: i_resetn_src is the combined active-low reset request
// Notes: the first stage is read only by the second
`timescale 1ns/1ps
module srrc_reset_sync (
	input wire i_clk,
	input wire i_resetn_src,
	output wire o_resetn
);
	reg stage1_q;
	reg stage2_q;

	// two-stage release chain
	always @(posedge i_clk or negedge i_resetn_src) begin
		if (!i_resetn_src) begin
			stage1_q <= 1'b0;
			stage2_q <= 1'b0;
		end else begin
			stage1_q <= 1'b1;
			stage2_q <= stage1_q;
		end
	end

	assign o_resetn = stage2_q;
endmodule // srrc_reset_sync

// [test_stop_release_and_reset_control.sv]
// Purpose: self-checking bench for srrc_ctrl
// Assumes: settle counts shortened to 8/16/32
// Notes: vector model answers 1234h
`timescale 1ns/1ps
`include "srrc_defines.vh"
module test_stop_release_and_reset_control;
	logic i_clk = 0, i_resetn = 0, i_wdt_overflow = 0, i_stop_instr = 0;
	logic i_irq_pending = 0, i_interrupt_mask_flag = 0, i_standby = 0;
	logic i_global_interrupt_enable = 0, i_osc_settle_select_we = 0;
	logic [2:0] i_osc_settle_select = 0, o_osc_settle_select;
	wire [15:0] i_vector_data;
	logic o_core_resetn, o_cpu_run, o_osc_stop, o_pins_hiz, o_vector_rd;
	logic o_pc_load, o_wake_service, o_wake_resume, o_ram_retain;
	logic [15:0] o_vector_addr, o_pc, o_wide_timer_count, o_wide_timer_compare;
	logic [7:0] o_processor_flags_word, o_cpu_clock_control, o_port_latch;
	logic [7:0] o_port_direction_reg, o_pullup_option_reg, o_pullup_option_reg_b;
	logic [7:0] o_interrupt_request_flags, o_interrupt_mask_reg;
	logic [7:0] o_external_edge_mode, o_wide_timer_mode, o_buzzer_control;
	logic [7:0] o_narrow_timer_count, o_narrow_timer_mode, o_transmit_shifter;
	logic [7:0] o_watchdog_clock_select, o_watchdog_mode_reg;
	logic [7:0] o_sync_serial_mode, o_async_serial_mode;
	logic [7:0] o_async_serial_status, o_baud_generator_control;
	int n_fail = 0, num_checks = 0, n;
	localparam logic [194:0] EXP = {72'h020200ff000000ff00, 32'h0000ffff,
		80'h0, 8'hff, 3'h4};
	// reset image in the order of EXP
	wire [194:0] img = {o_processor_flags_word, o_cpu_clock_control,
		o_port_latch, o_port_direction_reg, o_pullup_option_reg,
		o_pullup_option_reg_b, o_interrupt_request_flags,
		o_interrupt_mask_reg, o_external_edge_mode, o_wide_timer_count,
		o_wide_timer_compare, o_wide_timer_mode, o_buzzer_control,
		o_narrow_timer_count, o_narrow_timer_mode, o_watchdog_clock_select,
		o_watchdog_mode_reg, o_sync_serial_mode, o_async_serial_mode,
		o_async_serial_status, o_baud_generator_control, o_transmit_shifter,
		o_osc_settle_select};
	srrc_ctrl #(.SETTLE_2P12(8), .SETTLE_2P15(16), .SETTLE_2P17(32)) DUT (.*);
	srrc_core_model u_mem (.i_clk(i_clk), .i_vector_addr(o_vector_addr),
		.o_data(i_vector_data));
	// 100 MHz clock
	always #5 i_clk = ~i_clk;
	task chk(input logic [199:0] g, input logic [199:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(posedge i_clk);
		#1;
	endtask
	// count cycles until a wake pulse or a pc load
	task automatic wt(input bit w, output int c);
		c = 0;
		while (c < 300 &&
			(w ? !(o_wake_service | o_wake_resume) : !o_pc_load)) begin
			cyc(1);
			c++;
		end
	endtask
	// pin reset, settle, vector fetch
	task pin_reset(input logic r);
		i_resetn = 0;
		cyc(`SRRC_PIN_LOW_NS / `SRRC_CLK_NS);
		chk({img, o_core_resetn, o_cpu_run, o_pins_hiz}, {EXP, 3'b001});
		i_resetn = 1;
		cyc(4);
		chk({o_pins_hiz, o_ram_retain}, {1'b1, r});
		wt(0, n);
		chk(n >= 14 && n <= 18, 1);
		chk({o_pc, o_cpu_run, o_pins_hiz}, {16'h1234, 2'b10});
	endtask
	// stop, then wake by a pending request
	task wake(input logic [2:0] s, input int t, input logic m, input logic ie);
		i_osc_settle_select = s;
		i_osc_settle_select_we = 1;
		cyc(1);
		i_osc_settle_select_we = 0;
		chk(o_osc_settle_select, s);
		i_stop_instr = 1;
		cyc(1);
		i_stop_instr = 0;
		i_interrupt_mask_flag = m;
		i_global_interrupt_enable = ie;
		cyc(2);
		chk({o_osc_stop, o_cpu_run}, 2'b10);
		i_irq_pending = 1;
		if (m) begin
			cyc(40);
			chk({o_osc_stop, o_wake_resume}, 2'b10);
			i_interrupt_mask_flag = 0;
		end
		wt(1, n);
		chk(n >= t && n <= t + 4, 1);
		chk({o_wake_service, o_wake_resume, o_cpu_run}, {ie, !ie, 1'b1});
		i_irq_pending = 0;
		cyc(2);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// main sequence
	initial begin
		pin_reset(0);
		wake(3'h0, 8, 0, 0);
		wake(3'h2, 16, 0, 1);
		wake(3'h4, 32, 1, 0);
		i_wdt_overflow = 1;
		cyc(1);
		i_wdt_overflow = 0;
		cyc(2);
		chk({img, o_pins_hiz, o_cpu_run}, {EXP, 2'b10});
		wt(0, n);
		chk({n <= 24, o_pc}, {1'b1, 16'h1234});
		i_stop_instr = 1;
		cyc(1);
		i_stop_instr = 0;
		i_standby = 1;
		cyc(2);
		pin_reset(1);
		i_standby = 0;
		wrap_up;
	end
	// hang guard
	initial begin
		#100000;
		n_fail++;
		wrap_up;
	end
endmodule // test_stop_release_and_reset_control
